// ==== api_frame_pkg.sv ====
package api_frame_pkg;
	// Byte values with a fixed meaning on the serial stream.
	localparam logic [7:0]  DELIM_BYTE   = 8'h7E;
	localparam logic [7:0]  ESC_BYTE     = 8'h7D;
	localparam logic [7:0]  XON_BYTE     = 8'h11;
	localparam logic [7:0]  XOFF_BYTE    = 8'h13;
	localparam logic [7:0]  ESC_XOR      = 8'h20;
	localparam logic [7:0]  CSUM_GOOD    = 8'hFF;
	// Values of frame_mode_select; code 3 is unused and acts as transparent.
	localparam logic [1:0]  MODE_TRANSP  = 2'h0;
	localparam logic [1:0]  MODE_FRAMED  = 2'h1;
	localparam logic [1:0]  MODE_ESCAPED = 2'h2;
	// Status frame sent back after a bad frame: type, code, fixed length.
	localparam logic [7:0]  STATUS_TYPE  = 8'h8A;
	localparam logic [7:0]  ST_BAD_CSUM  = 8'h01;
	localparam logic [7:0]  ST_BAD_FRAME = 8'h02;
	localparam logic [15:0] STATUS_LEN   = 16'h0002;

	typedef enum logic [2:0] {
		T_IDLE  = 3'b000,
		T_DELIM = 3'b001,
		T_LEN_H = 3'b010,
		T_LEN_L = 3'b011,
		T_DATA  = 3'b100,
		T_CSUM  = 3'b101
	} tx_state_t;

	typedef enum logic [2:0] {
		R_HUNT  = 3'b000,
		R_LEN_H = 3'b001,
		R_LEN_L = 3'b010,
		R_DATA  = 3'b011,
		R_CSUM  = 3'b100
	} rx_state_t;

	// True for the four byte values that travel escaped.
	function automatic logic needs_esc(input logic [7:0] b);
		needs_esc = (b == DELIM_BYTE) || (b == ESC_BYTE) || (b == XON_BYTE) || (b == XOFF_BYTE);
	endfunction : needs_esc

	// Frame types the host understands; all others are dropped.
	function automatic logic known_type(input logic [7:0] t);
		unique case (t)
			8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8D, 8'h8E, 8'h90,
			8'h91, 8'h92, 8'h95, 8'h97, 8'h98, 8'hAD, 8'hAE: known_type = 1'b1;
			default: known_type = 1'b0;
		endcase
	endfunction : known_type
endpackage : api_frame_pkg

// ==== api_link_if.sv ====
`timescale 1ns/100ps
// Byte stream in each direction, valid/ready, both ends on i_core_clk.
interface api_link_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic       h2d_ready;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	logic       d2h_ready;

	modport dev_mp (
		input  h2d_data, h2d_valid, d2h_ready,
		output h2d_ready, d2h_data, d2h_valid
	);
	modport host_mp (
		input  d2h_data, d2h_valid, h2d_ready,
		output d2h_ready, h2d_data, h2d_valid
	);
endinterface : api_link_if

// ==== api_frame_dev.sv ====
`timescale 1ns/100ps
module api_frame_dev
	import api_frame_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic [1:0]  i_frame_mode_select,
	input  wire logic        i_link_is_uart,
	api_link_if.dev_mp       link,
	input  wire logic        i_tx_valid,
	input  wire logic [7:0]  i_tx_data,
	input  wire logic        i_tx_first,
	input  wire logic [15:0] i_tx_len,
	output logic             o_tx_ready,
	output logic             o_rx_valid,
	output logic [7:0]       o_rx_data,
	output logic             o_rx_first,
	output logic             o_rx_good,
	output logic             o_rx_bad
);
	logic [1:0]  mode;
	logic        transp;
	logic        esc_mode;
	tx_state_t   tx_st_q;
	logic        hold_v_q;
	logic [7:0]  hold_b_q;
	logic        hold_first_q;
	logic [15:0] hold_len_q;
	logic        take;
	logic        use_hold;
	logic        out_v_q;
	logic [7:0]  out_b_q;
	logic        esc_pend_q;
	logic [7:0]  esc_b_q;
	logic        stat_q;
	logic [7:0]  code_q;
	logic [15:0] tlen_q;
	logic [15:0] tcnt_q;
	logic [7:0]  tsum_q;
	logic        raw_ok;
	logic [7:0]  raw_b;
	logic        step;
	logic        err_pend_q;
	logic        err_set;
	logic [7:0]  err_code_q;
	rx_state_t   rx_st_q;
	logic        rx_rdy_q;
	logic        rx_take;
	logic [7:0]  rb;
	logic [7:0]  rv;
	logic        resync;
	logic        esc_in_q;
	logic [15:0] rlen_q;
	logic [15:0] rcnt_q;
	logic [7:0]  rsum_q;

	// Escaped selection falls back to plain framing on the synchronous link.
	always_comb begin
		if (i_frame_mode_select == MODE_ESCAPED && !i_link_is_uart) begin
			mode = MODE_FRAMED;
		end else if (i_frame_mode_select == 2'h3) begin
			mode = MODE_TRANSP;
		end else begin
			mode = i_frame_mode_select;
		end
	end
	assign transp   = (mode == MODE_TRANSP);
	assign esc_mode = (mode == MODE_ESCAPED);

	// One-byte holding stage between the user and the encoder.
	assign take = i_tx_valid && o_tx_ready;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hold_v_q     <= 1'b0;
			hold_b_q     <= 8'h00;
			hold_first_q <= 1'b0;
			hold_len_q   <= 16'h0000;
			o_tx_ready   <= 1'b0;
		end else begin
			hold_v_q   <= take || (hold_v_q && !use_hold);
			o_tx_ready <= !(take || (hold_v_q && !use_hold));
			if (take) begin
				hold_b_q     <= i_tx_data;
				hold_first_q <= i_tx_first;
				hold_len_q   <= i_tx_len;
			end
		end
	end

	// Next unescaped byte of the outgoing stream.
	always_comb begin
		raw_ok = 1'b1;
		raw_b  = DELIM_BYTE;
		unique case (tx_st_q)
			T_IDLE: begin
				raw_ok = transp && hold_v_q;
				raw_b  = hold_b_q;
			end
			T_DELIM: raw_b = DELIM_BYTE;
			T_LEN_H: raw_b = tlen_q[15:8];
			T_LEN_L: raw_b = tlen_q[7:0];
			T_DATA: begin
				if (stat_q) begin
					raw_b = (tcnt_q == 16'h0000) ? STATUS_TYPE : code_q;
				end else begin
					raw_ok = hold_v_q;
					raw_b  = hold_b_q;
				end
			end
			T_CSUM: raw_b = CSUM_GOOD - tsum_q;
			default: raw_ok = 1'b0;
		endcase
	end
	assign step     = !out_v_q && !esc_pend_q && raw_ok;
	assign use_hold = (step && ((tx_st_q == T_DATA && !stat_q) || tx_st_q == T_IDLE))
		|| (tx_st_q == T_IDLE && !transp && hold_v_q && !hold_first_q && !err_pend_q);

	// Output slot and escape insertion; the escape marker goes first.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			out_v_q    <= 1'b0;
			out_b_q    <= 8'h00;
			esc_pend_q <= 1'b0;
			esc_b_q    <= 8'h00;
		end else if (out_v_q) begin
			out_v_q <= !link.d2h_ready;
		end else if (esc_pend_q) begin
			out_v_q    <= 1'b1;
			out_b_q    <= esc_b_q;
			esc_pend_q <= 1'b0;
		end else if (step) begin
			out_v_q <= 1'b1;
			if (esc_mode && tx_st_q != T_DELIM && needs_esc(raw_b)) begin
				out_b_q    <= ESC_BYTE;
				esc_b_q    <= raw_b ^ ESC_XOR;
				esc_pend_q <= 1'b1;
			end else begin
				out_b_q <= raw_b;
			end
		end
	end
	assign link.d2h_valid = out_v_q;
	assign link.d2h_data  = out_b_q;

	// Encoder sequence; a pending status frame goes ahead of user frames.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tx_st_q <= T_IDLE;
			stat_q  <= 1'b0;
			code_q  <= 8'h00;
			tlen_q  <= 16'h0000;
			tcnt_q  <= 16'h0000;
			tsum_q  <= 8'h00;
		end else if (tx_st_q == T_IDLE) begin
			tcnt_q <= 16'h0000;
			tsum_q <= 8'h00;
			if (!transp && err_pend_q) begin
				stat_q  <= 1'b1;
				code_q  <= err_code_q;
				tlen_q  <= STATUS_LEN;
				tx_st_q <= T_DELIM;
			end else if (!transp && hold_v_q && hold_first_q) begin
				stat_q  <= 1'b0;
				tlen_q  <= hold_len_q;
				tx_st_q <= T_DELIM;
			end
		end else if (step) begin
			unique case (tx_st_q)
				T_DELIM: tx_st_q <= T_LEN_H;
				T_LEN_H: tx_st_q <= T_LEN_L;
				T_LEN_L: tx_st_q <= (tlen_q == 16'h0000) ? T_CSUM : T_DATA;
				T_DATA: begin
					tsum_q <= tsum_q + raw_b;
					tcnt_q <= tcnt_q + 16'h0001;
					if (tcnt_q == tlen_q - 16'h0001) begin
						tx_st_q <= T_CSUM;
					end
				end
				default: tx_st_q <= T_IDLE;
			endcase
		end
	end

	// Error flag toward the encoder; a new error wins over the clear.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			err_pend_q <= 1'b0;
			err_code_q <= 8'h00;
		end else if (err_set) begin
			err_pend_q <= 1'b1;
			err_code_q <= (rx_st_q == R_CSUM) ? ST_BAD_CSUM : ST_BAD_FRAME;
		end else if (tx_st_q == T_IDLE && !transp) begin
			err_pend_q <= 1'b0;
		end
	end

	// Receive decode: delimiter hunt, unescape, length, checksum.
	assign rx_take = link.h2d_valid && rx_rdy_q;
	assign rb      = link.h2d_data;
	assign rv      = esc_in_q ? (rb ^ ESC_XOR) : rb;
	assign resync  = (rb == DELIM_BYTE) && !esc_in_q
		&& (esc_mode || rx_st_q == R_HUNT);
	assign err_set = rx_take && !transp && !resync && !(esc_mode && rb == ESC_BYTE && !esc_in_q)
		&& ((rx_st_q == R_CSUM && rsum_q + rv != CSUM_GOOD)
		|| (rx_st_q == R_LEN_L && {rlen_q[15:8], rv} == 16'h0000));
	assign link.h2d_ready = rx_rdy_q;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_rdy_q   <= 1'b0;
			rx_st_q    <= R_HUNT;
			esc_in_q   <= 1'b0;
			rlen_q     <= 16'h0000;
			rcnt_q     <= 16'h0000;
			rsum_q     <= 8'h00;
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
			o_rx_first <= 1'b0;
			o_rx_good  <= 1'b0;
			o_rx_bad   <= 1'b0;
		end else begin
			rx_rdy_q   <= 1'b1;
			o_rx_valid <= 1'b0;
			o_rx_first <= 1'b0;
			o_rx_good  <= 1'b0;
			o_rx_bad   <= 1'b0;
			if (rx_take && transp) begin
				o_rx_valid <= 1'b1;
				o_rx_data  <= rb;
				rx_st_q    <= R_HUNT;
				esc_in_q   <= 1'b0;
			end else if (rx_take && resync) begin
				rx_st_q  <= R_LEN_H;
				esc_in_q <= 1'b0;
				rsum_q   <= 8'h00;
				rcnt_q   <= 16'h0000;
			end else if (rx_take && esc_mode && rb == ESC_BYTE && !esc_in_q
				&& rx_st_q != R_HUNT) begin
				esc_in_q <= 1'b1;
			end else if (rx_take) begin
				esc_in_q <= 1'b0;
				unique case (rx_st_q)
					R_HUNT: ;
					R_LEN_H: begin
						rlen_q[15:8] <= rv;
						rx_st_q      <= R_LEN_L;
					end
					R_LEN_L: begin
						rlen_q[7:0] <= rv;
						rx_st_q     <= ({rlen_q[15:8], rv} == 16'h0000) ? R_HUNT : R_DATA;
					end
					R_DATA: begin
						o_rx_valid <= 1'b1;
						o_rx_data  <= rv;
						o_rx_first <= (rcnt_q == 16'h0000);
						rsum_q     <= rsum_q + rv;
						rcnt_q     <= rcnt_q + 16'h0001;
						if (rcnt_q == rlen_q - 16'h0001) begin
							rx_st_q <= R_CSUM;
						end
					end
					default: begin
						o_rx_good <= (rsum_q + rv == CSUM_GOOD);
						o_rx_bad  <= (rsum_q + rv != CSUM_GOOD);
						rx_st_q   <= R_HUNT;
					end
				endcase
			end
		end
	end
endmodule : api_frame_dev

// ==== api_frame_host.sv ====
`timescale 1ns/100ps
module api_frame_host
	import api_frame_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic [1:0]  i_frame_mode_select,
	api_link_if.host_mp      link,
	input  wire logic        i_tx_valid,
	input  wire logic [7:0]  i_tx_data,
	input  wire logic        i_tx_first,
	input  wire logic [15:0] i_tx_len,
	output logic             o_tx_ready,
	output logic             o_rx_valid,
	output logic [7:0]       o_rx_data,
	output logic             o_rx_first,
	output logic             o_rx_good,
	output logic             o_rx_bad
);
	tx_state_t   tx_st_q;
	rx_state_t   rx_st_q;
	logic        esc_mode;
	logic        transp;
	logic        out_v_q;
	logic [7:0]  out_b_q;
	logic        esc_pend_q;
	logic [7:0]  esc_b_q;
	logic [15:0] tlen_q;
	logic [15:0] tcnt_q;
	logic [7:0]  tsum_q;
	logic [7:0]  raw_b;
	logic        step;
	logic        rx_rdy_q;
	logic        rx_take;
	logic [7:0]  rb;
	logic [7:0]  rv;
	logic        esc_in_q;
	logic        drop_q;
	logic [15:0] rlen_q;
	logic [15:0] rcnt_q;
	logic [7:0]  rsum_q;

	assign transp   = (i_frame_mode_select != MODE_FRAMED) && (i_frame_mode_select != MODE_ESCAPED);
	assign esc_mode = (i_frame_mode_select == MODE_ESCAPED);

	// The host encodes straight from the user byte; no holding stage.
	always_comb begin
		unique case (tx_st_q)
			T_IDLE:  raw_b = i_tx_data;
			T_DELIM: raw_b = DELIM_BYTE;
			T_LEN_H: raw_b = tlen_q[15:8];
			T_LEN_L: raw_b = tlen_q[7:0];
			T_DATA:  raw_b = i_tx_data;
			default: raw_b = CSUM_GOOD - tsum_q;
		endcase
	end
	assign step = !out_v_q && !esc_pend_q
		&& ((tx_st_q != T_IDLE && tx_st_q != T_DATA) || (i_tx_valid && o_tx_ready));

	// Ready is offered only where a user byte can be placed this cycle.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_tx_ready <= 1'b0;
			out_v_q    <= 1'b0;
			out_b_q    <= 8'h00;
			esc_pend_q <= 1'b0;
			esc_b_q    <= 8'h00;
		end else begin
			o_tx_ready <= !o_tx_ready && !out_v_q && !esc_pend_q
				&& (tx_st_q == T_DATA || (tx_st_q == T_IDLE && transp));
			if (out_v_q) begin
				out_v_q <= !link.h2d_ready;
			end else if (esc_pend_q) begin
				out_v_q    <= 1'b1;
				out_b_q    <= esc_b_q;
				esc_pend_q <= 1'b0;
			end else if (step && !(tx_st_q == T_IDLE && !transp)) begin
				out_v_q <= 1'b1;
				if (esc_mode && tx_st_q != T_DELIM && needs_esc(raw_b)) begin
					out_b_q    <= ESC_BYTE;
					esc_b_q    <= raw_b ^ ESC_XOR;
					esc_pend_q <= 1'b1;
				end else begin
					out_b_q <= raw_b;
				end
			end
		end
	end
	assign link.h2d_valid = out_v_q;
	assign link.h2d_data  = out_b_q;

	// A frame opens when the user raises i_tx_first with the length.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tx_st_q <= T_IDLE;
			tlen_q  <= 16'h0000;
			tcnt_q  <= 16'h0000;
			tsum_q  <= 8'h00;
		end else if (tx_st_q == T_IDLE) begin
			tcnt_q <= 16'h0000;
			tsum_q <= 8'h00;
			if (!transp && i_tx_valid && i_tx_first) begin
				tlen_q  <= i_tx_len;
				tx_st_q <= T_DELIM;
			end
		end else if (step) begin
			unique case (tx_st_q)
				T_DELIM: tx_st_q <= T_LEN_H;
				T_LEN_H: tx_st_q <= T_LEN_L;
				T_LEN_L: tx_st_q <= (tlen_q == 16'h0000) ? T_CSUM : T_DATA;
				T_DATA: begin
					tsum_q <= tsum_q + raw_b;
					tcnt_q <= tcnt_q + 16'h0001;
					if (tcnt_q == tlen_q - 16'h0001) begin
						tx_st_q <= T_CSUM;
					end
				end
				default: tx_st_q <= T_IDLE;
			endcase
		end
	end

	// Receive side; frames of unknown type produce no output at all.
	assign rx_take        = link.d2h_valid && rx_rdy_q;
	assign rb             = link.d2h_data;
	assign rv             = esc_in_q ? (rb ^ ESC_XOR) : rb;
	assign link.d2h_ready = rx_rdy_q;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_rdy_q   <= 1'b0;
			rx_st_q    <= R_HUNT;
			esc_in_q   <= 1'b0;
			drop_q     <= 1'b0;
			rlen_q     <= 16'h0000;
			rcnt_q     <= 16'h0000;
			rsum_q     <= 8'h00;
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
			o_rx_first <= 1'b0;
			o_rx_good  <= 1'b0;
			o_rx_bad   <= 1'b0;
		end else begin
			rx_rdy_q   <= 1'b1;
			o_rx_valid <= 1'b0;
			o_rx_first <= 1'b0;
			o_rx_good  <= 1'b0;
			o_rx_bad   <= 1'b0;
			if (rx_take && transp) begin
				o_rx_valid <= 1'b1;
				o_rx_data  <= rb;
			end else if (rx_take && rb == DELIM_BYTE && !esc_in_q
				&& (esc_mode || rx_st_q == R_HUNT)) begin
				rx_st_q <= R_LEN_H;
				rsum_q  <= 8'h00;
				rcnt_q  <= 16'h0000;
			end else if (rx_take && esc_mode && rb == ESC_BYTE && !esc_in_q
				&& rx_st_q != R_HUNT) begin
				esc_in_q <= 1'b1;
			end else if (rx_take) begin
				esc_in_q <= 1'b0;
				unique case (rx_st_q)
					R_HUNT: ;
					R_LEN_H: begin
						rlen_q[15:8] <= rv;
						rx_st_q      <= R_LEN_L;
					end
					R_LEN_L: begin
						rlen_q[7:0] <= rv;
						rx_st_q     <= ({rlen_q[15:8], rv} == 16'h0000) ? R_HUNT : R_DATA;
					end
					R_DATA: begin
						if (rcnt_q == 16'h0000) begin
							drop_q <= !known_type(rv);
						end
						o_rx_valid <= (rcnt_q == 16'h0000) ? known_type(rv) : !drop_q;
						o_rx_data  <= rv;
						o_rx_first <= (rcnt_q == 16'h0000) && known_type(rv);
						rsum_q     <= rsum_q + rv;
						rcnt_q     <= rcnt_q + 16'h0001;
						if (rcnt_q == rlen_q - 16'h0001) begin
							rx_st_q <= R_CSUM;
						end
					end
					default: begin
						o_rx_good <= !drop_q && (rsum_q + rv == CSUM_GOOD);
						o_rx_bad  <= !drop_q && (rsum_q + rv != CSUM_GOOD);
						rx_st_q   <= R_HUNT;
					end
				endcase
			end
		end
	end
endmodule : api_frame_host

// ==== api_link_asserts.sv ====
`timescale 1ns/100ps
// Watches the byte link between the two ends of the codec.
module api_link_asserts (
	input wire logic        i_core_clk,
	input wire logic        i_arst_n,
	input wire logic [1:0]  i_frame_mode_select,
	input wire logic        i_link_is_uart,
	input wire logic [7:0]  h2d_data,
	input wire logic        h2d_valid,
	input wire logic        h2d_ready,
	input wire logic [7:0]  d2h_data,
	input wire logic        d2h_valid,
	input wire logic        d2h_ready
);
	logic        esc_mode;
	logic        d2h_take;
	logic        d2h_esc_q;
	logic        h2d_esc_q;
	logic [2:0]  pos_q;
	logic [15:0] rem_q;
	logic [7:0]  sum_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	// Escape pairs only mean something in escaped mode on the asynchronous link.
	assign esc_mode = (i_frame_mode_select == 2'h2) && i_link_is_uart;
	assign d2h_take = d2h_valid && d2h_ready;

	// A marker is remembered so that the byte after it can be judged.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			d2h_esc_q <= 1'b0;
			h2d_esc_q <= 1'b0;
		end else begin
			if (d2h_take) d2h_esc_q <= esc_mode && (d2h_data == 8'h7D);
			if (h2d_valid && h2d_ready) h2d_esc_q <= esc_mode && (h2d_data == 8'h7D);
		end
	end

	// Frame position on the device output; framed mode only, as escapes would shift it.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pos_q <= 3'h0;
			rem_q <= 16'h0000;
			sum_q <= 8'h00;
		end else if (i_frame_mode_select != 2'h1) begin
			pos_q <= 3'h0;
		end else if (d2h_take) begin
			if (pos_q == 3'h1) rem_q[15:8] <= d2h_data;
			if (pos_q == 3'h2) rem_q[7:0] <= d2h_data;
			if (pos_q == 3'h3) rem_q <= rem_q - 16'h0001;
			sum_q <= (pos_q == 3'h3) ? sum_q + d2h_data : 8'h00;
			pos_q <= (pos_q < 3'h3) ? pos_q + 3'h1 : (pos_q == 3'h4) ? 3'h0 :
				(rem_q == 16'h0001) ? 3'h4 : 3'h3;
		end
	end

	a_h2d_ready_on: assert property ($past(i_arst_n) |-> h2d_ready)
		else $error("device stopped taking link bytes");
	a_d2h_esc_pair: assert property (d2h_esc_q && d2h_valid |->
		(d2h_data ^ 8'h20) inside {8'h7E, 8'h7D, 8'h11, 8'h13})
		else $error("device escaped a byte that needs no escape");
	a_h2d_esc_pair: assert property (h2d_esc_q && h2d_valid |->
		(h2d_data ^ 8'h20) inside {8'h7E, 8'h7D, 8'h11, 8'h13})
		else $error("host escaped a byte that needs no escape");
	a_d2h_no_flow: assert property (esc_mode && d2h_valid |->
		!(d2h_data inside {8'h11, 8'h13}))
		else $error("device sent a flow code unescaped");
	a_h2d_no_flow: assert property (esc_mode && h2d_valid |->
		!(h2d_data inside {8'h11, 8'h13}))
		else $error("host sent a flow code unescaped");
	a_d2h_delim_first: assert property (i_frame_mode_select == 2'h1 && pos_q == 3'h0 &&
		d2h_valid |-> d2h_data == 8'h7E)
		else $error("device frame without delimiter");
	a_d2h_len_nonzero: assert property (i_frame_mode_select == 2'h1 && pos_q == 3'h2 &&
		d2h_take |-> {rem_q[15:8], d2h_data} != 16'h0000)
		else $error("device frame without a type byte");
	a_d2h_csum_ok: assert property (i_frame_mode_select == 2'h1 && pos_q == 3'h4 &&
		d2h_valid |-> 8'(sum_q + d2h_data) == 8'hFF)
		else $error("device checksum wrong");
endmodule : api_link_asserts

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	typedef logic [7:0] bytes_t[$];
	logic        core_clk, arst_n, uart1, uart2, h_tv, h_tf, d_tv, d_tf, h_tr, d_tr;
	logic [1:0]  mode, mode2;
	logic [7:0]  h_td, d_td, h_rd, d_rd, e_rd;
	logic [15:0] h_tl, d_tl;
	logic        h_rv, h_rf, h_rg, h_rb, d_rv, d_rf, d_rg, d_rb, e_rv, e_rf, e_rg, e_rb;
	int          mismatches, n_compared, d_first, d_good, d_bad, h_good, e_first, e_good;
	int          e_bad, n_w2, d_n, h_n, d2h_n, h_first, h_bad;
	bytes_t      w_h2d, w_d2h, w2, d_rx, h_rx, e_rx;

	api_link_if lk();
	api_link_if lk2();
	api_frame_dev api_frame_dev_inst (.i_core_clk(core_clk), .i_arst_n(arst_n),
		.i_frame_mode_select(mode), .i_link_is_uart(uart1), .link(lk), .i_tx_valid(d_tv),
		.i_tx_data(d_td), .i_tx_first(d_tf), .i_tx_len(d_tl), .o_tx_ready(d_tr),
		.o_rx_valid(d_rv), .o_rx_data(d_rd), .o_rx_first(d_rf), .o_rx_good(d_rg), .o_rx_bad(d_rb));
	api_frame_host api_frame_host_inst (.i_core_clk(core_clk), .i_arst_n(arst_n),
		.i_frame_mode_select(mode), .link(lk), .i_tx_valid(h_tv), .i_tx_data(h_td),
		.i_tx_first(h_tf), .i_tx_len(h_tl), .o_tx_ready(h_tr), .o_rx_valid(h_rv),
		.o_rx_data(h_rd), .o_rx_first(h_rf), .o_rx_good(h_rg), .o_rx_bad(h_rb));
	// The second device has no user sender; its link is driven by the bench to break the framing, and it answers with status frames.
	api_frame_dev api_frame_dev_inst_b (.i_core_clk(core_clk), .i_arst_n(arst_n),
		.i_frame_mode_select(mode2), .i_link_is_uart(uart2), .link(lk2), .i_tx_valid(1'b0),
		.i_tx_data(8'h00), .i_tx_first(1'b0), .i_tx_len(16'h0000), .o_tx_ready(),
		.o_rx_valid(e_rv), .o_rx_data(e_rd), .o_rx_first(e_rf), .o_rx_good(e_rg), .o_rx_bad(e_rb));
	api_link_asserts api_link_asserts_inst (.i_core_clk(core_clk), .i_arst_n(arst_n),
		.i_frame_mode_select(mode), .i_link_is_uart(uart1), .h2d_data(lk.h2d_data),
		.h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
		.d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));

	// Clock at 40 MHz.
	always #12.5 core_clk = ~core_clk;

	// Everything taken on the wires, apart from the bench bytes into the second device, and delivered to the users is logged here.
	always @(posedge core_clk) begin
		if (lk.h2d_valid && lk.h2d_ready) w_h2d.push_back(lk.h2d_data);
		if (lk.d2h_valid && lk.d2h_ready) w_d2h.push_back(lk.d2h_data);
		if (lk2.d2h_valid && lk2.d2h_ready) w2.push_back(lk2.d2h_data);
		if (d_rv) d_rx.push_back(d_rd);
		if (h_rv) h_rx.push_back(h_rd);
		if (e_rv) e_rx.push_back(e_rd);
		d_first += d_rv & d_rf;
		e_first += e_rv & e_rf;
		d_good += d_rg;
		d_bad += d_rb;
		h_good += h_rg;
		h_first += h_rv & h_rf;
		h_bad += h_rb;
		e_good += e_rg;
		e_bad += e_rb;
		n_w2 = w2.size();
		d_n = d_rx.size();
		h_n = h_rx.size();
		d2h_n = w_d2h.size();
	end

	task automatic stop_test();
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic chk_q(input bytes_t s, input bytes_t e);
		chk(s.size(), e.size());
		foreach (e[i]) chk((i < s.size()) ? s[i] : 8'hxx, e[i]);
	endtask : chk_q

	task automatic tick();
		@(posedge core_clk);
		#2;
	endtask : tick

	task automatic wait_ge(ref int c, input int t);
		for (int n = 0; n < 600 && c < t; n++) tick();
		if (c < t) begin
			mismatches++;
			stop_test();
		end
	endtask : wait_ge

	task automatic clear();
		w_h2d.delete();
		w_d2h.delete();
		w2.delete();
		d_rx.delete();
		h_rx.delete();
		e_rx.delete();
		{d_first, d_good, d_bad, h_good, e_first, e_good, e_bad} = '0;
		{n_w2, d_n, h_n, d2h_n, h_first, h_bad} = '0;
	endtask : clear

	function automatic logic rdy(input int s);
		return (s == 2) ? lk2.h2d_ready : (s == 1) ? d_tr : h_tr;
	endfunction : rdy

	// Sends bytes from the host user (0), the device user (1) or raw onto the second link (2).
	task automatic send(input int s, input bytes_t b);
		foreach (b[i]) begin
			case (s)
				0: {h_tv, h_td, h_tf, h_tl} = {1'b1, b[i], i == 0, 16'(b.size())};
				1: {d_tv, d_td, d_tf, d_tl} = {1'b1, b[i], i == 0, 16'(b.size())};
				default: {lk2.h2d_valid, lk2.h2d_data} = {1'b1, b[i]};
			endcase
			for (int n = 0; n < 600 && rdy(s) !== 1'b1; n++) tick();
			if (rdy(s) !== 1'b1) begin
				mismatches++;
				stop_test();
			end
			tick();
		end
		{h_tv, d_tv, lk2.h2d_valid} = 3'b000;
		lk2.h2d_data = ~lk2.h2d_data;
	endtask : send

	// Expected wire image of a frame; the escape set is spelled out here on purpose.
	function automatic bytes_t enc(input bit e, input bytes_t p);
		bytes_t     f;
		bytes_t     o;
		logic [7:0] s;
		s = 8'h00;
		foreach (p[i]) s += p[i];
		f = {8'(p.size() >> 8), 8'(p.size())};
		f = {f, p, 8'(8'hFF - s)};
		o = {8'h7E};
		foreach (f[i]) begin
			if (e && f[i] inside {8'h7E, 8'h7D, 8'h11, 8'h13})
				o = {o, 8'h7D, f[i] ^ 8'h20};
			else
				o.push_back(f[i]);
		end
		return o;
	endfunction : enc

	task automatic t_framed();
		bytes_t p;
		bytes_t q;
		p = {8'h08, 8'h01, 8'h50, 8'h01, 8'h00, 8'h48, 8'h65};
		q = {8'h88, 8'h01, 8'h7E, 8'hFF};
		mode = 2'h1;
		clear();
		send(0, p);
		wait_ge(d_good, 1);
		chk_q(w_h2d, enc(0, p));
		chk_q(d_rx, p);
		chk(d_first, 1);
		chk(d_bad, 0);
		send(1, q);
		wait_ge(h_good, 1);
		chk_q(w_d2h, enc(0, q));
		chk_q(h_rx, q);
		// An unknown frame type must vanish at the host.
		send(1, {8'h23, 8'h05});
		// Eight wire bytes of the first frame and six of the dropped one.
		wait_ge(d2h_n, 14);
		tick();
		chk(h_good, 1);
		chk(h_rx.size(), 4);
		chk(h_first + h_bad, 1);
	endtask : t_framed

	task automatic t_escaped();
		bytes_t     p;
		logic [7:0] s;
		p = {8'h08, 8'h7E, 8'h7D, 8'h11, 8'h13};
		for (int i = 0; i < 11; i++) p.push_back(8'(i * 7));
		s = 8'h00;
		foreach (p[i]) s += p[i];
		// Length 0x11 and checksum 0x7E both travel escaped.
		p.push_back(8'h81 - s);
		mode = 2'h2;
		clear();
		send(0, p);
		wait_ge(d_good, 1);
		chk_q(w_h2d, enc(1, p));
		chk_q(d_rx, p);
		send(1, {8'h90, 8'h13, 8'h7D, 8'h7E});
		wait_ge(h_good, 1);
		chk_q(w_d2h, enc(1, {8'h90, 8'h13, 8'h7D, 8'h7E}));
		chk_q(h_rx, {8'h90, 8'h13, 8'h7D, 8'h7E});
	endtask : t_escaped

	task automatic t_transparent();
		mode = 2'h0;
		clear();
		send(0, {8'h7E, 8'h7D, 8'h11, 8'h00});
		wait_ge(d_n, 4);
		chk_q(w_h2d, {8'h7E, 8'h7D, 8'h11, 8'h00});
		chk_q(d_rx, {8'h7E, 8'h7D, 8'h11, 8'h00});
		chk(d_first + d_good, 0);
		send(1, {8'h13, 8'h7E});
		wait_ge(h_n, 2);
		chk_q(h_rx, {8'h13, 8'h7E});
	endtask : t_transparent

	task automatic t_faults();
		{mode2, uart2} = {2'h1, 1'b1};
		clear();
		send(2, {8'h55, 8'hAA, 8'h7E, 8'h00, 8'h02, 8'h08, 8'h01, 8'h00});
		wait_ge(n_w2, 6);
		chk_q(w2, {8'h7E, 8'h00, 8'h02, 8'h8A, 8'h01, 8'h74});
		chk(e_bad * 2 + e_good, 2);
		chk_q(e_rx, {8'h08, 8'h01});
		mode2 = 2'h2;
		clear();
		send(2, {8'h7E, 8'h00, 8'h05, 8'h08, 8'h01, 8'h7E, 8'h00, 8'h02, 8'h08, 8'h01, 8'hF6});
		wait_ge(e_good, 1);
		chk(e_first, 2);
		chk(e_bad + n_w2, 0);
		// Without the asynchronous link the marker is plain data.
		uart2 = 1'b0;
		clear();
		send(2, {8'h7E, 8'h00, 8'h02, 8'h08, 8'h7D, 8'h7A});
		wait_ge(e_good, 1);
		chk_q(e_rx, {8'h08, 8'h7D});
		// A frame with no data is refused and answered with a status frame.
		{mode2, uart2} = {2'h1, 1'b1};
		clear();
		send(2, {8'h7E, 8'h00, 8'h00});
		wait_ge(n_w2, 6);
		chk_q(w2, {8'h7E, 8'h00, 8'h02, 8'h8A, 8'h02, 8'h73});
	endtask : t_faults

	// Reset for six cycles, then each scenario in turn.
	initial begin
		{core_clk, arst_n, uart2, h_tv, h_tf, d_tv, d_tf} = '0;
		{mode, mode2, h_td, d_td, h_tl, d_tl} = '0;
		{lk2.h2d_valid, lk2.h2d_data, lk2.d2h_ready} = {1'b0, 8'h00, 1'b1};
		uart1 = 1'b1;
		{mismatches, n_compared} = '0;
		clear();
		repeat (6) @(posedge core_clk);
		#2;
		arst_n = 1'b1;
		tick();
		tick();
		t_framed();
		t_escaped();
		t_transparent();
		t_faults();
		stop_test();
	end
endmodule : tb_top
